//--- inc/sbr_regs.svh
// register offsets, field positions, reset values and link constants
// assumes: included by the package user and the core, by bare name
`ifndef SBR_REGS_SVH
`define SBR_REGS_SVH
// target addresses, write and read direction
`define SBR_ADDR_WR        8'hdc
`define SBR_ADDR_RD        8'hdd
// register indices
`define SBR_IDX_MODE       8'h00
`define SBR_IDX_ENABLE     8'h01
`define SBR_IDX_STOPPABLE  8'h02
`define SBR_IDX_RSVD       8'h03
`define SBR_IDX_COUNT      8'h06
// field positions in the mode register
`define SBR_PD_HIZ_BIT     7
`define SBR_STOP_HIZ_BIT   6
`define SBR_LOW_BW_BIT     2
`define SBR_ZDB_BIT        1
`define SBR_UNITY_BIT      0
// reset values
`define SBR_MODE_RST       8'h07
`define SBR_ENABLE_RST     8'hff
`define SBR_STOPPABLE_RST  8'h00
`define SBR_RSVD_RST       8'h00
`define SBR_COUNT_RST      8'h05
// pairs that may be stopped at all
`define SBR_STOP_MASK      8'h66
// bits in a byte on the link
`define SBR_BYTE_BITS      4'h8
`endif

//--- inc/sbr_pkg.sv
// types shared by the serial register target
// assumes: nothing beyond a SystemVerilog compiler
package sbr_pkg;
    // link state of the target
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_HACK} sbr_state_t;
    // meaning of the byte being received
    typedef enum logic [1:0] {PH_ADDR, PH_INDEX, PH_COUNT, PH_DATA} sbr_phase_t;
endpackage

//--- core/sbr_target.sv
// serial register target for an eight pair differential clock buffer
// assumes: SCL, SDA and control pins come from outside, sampled on CLK
//
// Summary of operation
// - acknowledge write address after start
// - acknowledge index, keep as first register
// - acknowledge read address after repeated start
// - first read byte is the count
// - then registers from index onward
// - mode bit 2 picks loop bandwidth
// - enable register bit per pair
// - stoppable bits 1,2,5,6 only
// - register 3 reserved, plain storage
// - count register sets reported count
// - power-down drives true high or floats
// - stop halts stoppable pairs, drive style
`timescale 1ns/10ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_target (
    // clock, reset, enable
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    // two-wire link
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    // control pins, active low
    input  wire logic       POWER_DOWN_N,
    input  wire logic       OUTPUT_HALT_N,
    // configuration to the analog core
    output logic            LOOP_BANDWIDTH_SEL,
    output logic            ZERO_DELAY_MODE,
    output logic            INPUT_DIVIDE_SEL,
    // per pair drive state
    output logic [7:0]      PAIR_RUN,
    output logic [7:0]      PAIR_TRUE_OE,
    output logic [7:0]      PAIR_COMP_OE
);
    // synchronisers, first stage read only by second
    logic [1:0]             scl_sync;
    logic [1:0]             sda_sync;
    logic [1:0]             pd_sync;
    logic [1:0]             halt_sync;
    logic                   scl_d;     // previous synced clock
    logic                   sda_d;     // previous synced data
    // protocol state
    sbr_pkg::sbr_state_t    state_reg;
    sbr_pkg::sbr_phase_t    phase_reg;
    logic [7:0]             shift_reg;  // received or outgoing byte
    logic [3:0]             bitcnt_reg; // bits moved in this byte
    logic [7:0]             index_reg;  // current register index
    logic                   read_reg;   // direction of this access
    logic                   sda_oe_reg; // pulling the data line low
    // registers
    logic [7:0]             mode_reg;
    logic [7:0]             enable_reg;
    logic [7:0]             stoppable_reg;
    logic [7:0]             rsvd_reg;
    logic [7:0]             count_reg;

    // line events, taken from the synced copies only
    wire scl_s     = scl_sync[1];
    wire sda_s     = sda_sync[1];
    wire scl_rise  = CE & scl_s & ~scl_d;
    wire scl_fall  = CE & ~scl_s & scl_d;
    wire start_ev  = CE & scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev   = CE & scl_s & scl_d & ~sda_d & sda_s;
    wire byte_done = (bitcnt_reg == `SBR_BYTE_BITS);
    // address match for either direction
    wire addr_wr   = (shift_reg == `SBR_ADDR_WR);
    wire addr_rd   = (shift_reg == `SBR_ADDR_RD);
    // a finished received byte, decided on the falling clock
    wire rx_end    = scl_fall & (state_reg == sbr_pkg::ST_RX) & byte_done;
    wire wr_strobe = rx_end & (phase_reg == sbr_pkg::PH_DATA);
    // read data selection, unmapped indices give zero
    wire [7:0] rd_data =
        (index_reg == `SBR_IDX_MODE)      ? mode_reg      :
        (index_reg == `SBR_IDX_ENABLE)    ? enable_reg    :
        (index_reg == `SBR_IDX_STOPPABLE) ? stoppable_reg :
        (index_reg == `SBR_IDX_RSVD)      ? rsvd_reg      :
        (index_reg == `SBR_IDX_COUNT)     ? count_reg     : 8'h00;

    // two-flop sampling of the link and control pin inputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_sync  <= 2'h3;
            sda_sync  <= 2'h3;
            pd_sync   <= 2'h3;
            halt_sync <= 2'h3;
            scl_d     <= 1'h1;
            sda_d     <= 1'h1;
        end else if (CE) begin
            scl_sync  <= {scl_sync[0], SCL};
            sda_sync  <= {sda_sync[0], SDA_IN};
            pd_sync   <= {pd_sync[0], POWER_DOWN_N};
            halt_sync <= {halt_sync[0], OUTPUT_HALT_N};
            scl_d     <= scl_s;
            sda_d     <= sda_s;
        end
    end

    // link state machine
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg  <= sbr_pkg::ST_IDLE;
            phase_reg  <= sbr_pkg::PH_ADDR;
            shift_reg  <= 8'h00;
            bitcnt_reg <= 4'h0;
            index_reg  <= 8'h00;
            read_reg   <= 1'h0;
            sda_oe_reg <= 1'h0;
        end else if (stop_ev) begin
            // stop ends any access and frees the line
            state_reg  <= sbr_pkg::ST_IDLE;
            sda_oe_reg <= 1'h0;
        end else if (start_ev) begin
            // start or repeated start, address follows
            state_reg  <= sbr_pkg::ST_RX;
            phase_reg  <= sbr_pkg::PH_ADDR;
            bitcnt_reg <= 4'h0;
            sda_oe_reg <= 1'h0;
        end else begin
            case (state_reg)
                sbr_pkg::ST_RX: begin
                    // shift in on rising clock
                    if (scl_rise && !byte_done) begin
                        shift_reg  <= {shift_reg[6:0], sda_s};
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end else if (rx_end) begin
                        sda_oe_reg <= 1'h1;
                        state_reg  <= sbr_pkg::ST_ACK;
                        case (phase_reg)
                            sbr_pkg::PH_ADDR: begin
                                // foreign address: stay silent
                                if (!(addr_wr || addr_rd)) begin
                                    sda_oe_reg <= 1'h0;
                                    state_reg  <= sbr_pkg::ST_IDLE;
                                end
                                read_reg <= addr_rd;
                            end
                            sbr_pkg::PH_INDEX: index_reg <= shift_reg;
                            sbr_pkg::PH_DATA:  index_reg <= index_reg + 8'h01;
                            default: ;
                        endcase
                    end
                end
                sbr_pkg::ST_ACK: begin
                    // release after the acknowledge clock
                    if (scl_fall) begin
                        bitcnt_reg <= 4'h0;
                        if (read_reg && phase_reg == sbr_pkg::PH_ADDR) begin
                            // count byte leads the read data
                            sda_oe_reg <= ~count_reg[7];
                            shift_reg  <= {count_reg[6:0], 1'h0};
                            bitcnt_reg <= 4'h1;
                            state_reg  <= sbr_pkg::ST_TX;
                        end else begin
                            sda_oe_reg <= 1'h0;
                            state_reg  <= sbr_pkg::ST_RX;
                            case (phase_reg)
                                sbr_pkg::PH_ADDR:  phase_reg <= sbr_pkg::PH_INDEX;
                                sbr_pkg::PH_INDEX: phase_reg <= sbr_pkg::PH_COUNT;
                                default:           phase_reg <= sbr_pkg::PH_DATA;
                            endcase
                        end
                    end
                end
                sbr_pkg::ST_TX: begin
                    // next bit out on each falling clock
                    if (scl_fall) begin
                        if (byte_done) begin
                            sda_oe_reg <= 1'h0;
                            state_reg  <= sbr_pkg::ST_HACK;
                        end else begin
                            sda_oe_reg <= ~shift_reg[7];
                            shift_reg  <= {shift_reg[6:0], 1'h0};
                            bitcnt_reg <= bitcnt_reg + 4'h1;
                        end
                    end
                end
                sbr_pkg::ST_HACK: begin
                    // host answer: not-acknowledge ends the read
                    if (scl_rise && sda_s) begin
                        state_reg <= sbr_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        // acknowledged: next register, index moves on
                        sda_oe_reg <= ~rd_data[7];
                        shift_reg  <= {rd_data[6:0], 1'h0};
                        bitcnt_reg <= 4'h1;
                        index_reg  <= index_reg + 8'h01;
                        state_reg  <= sbr_pkg::ST_TX;
                    end
                end
                default: ;
            endcase
        end
    end

    // register writes from the data phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_reg      <= `SBR_MODE_RST;
            enable_reg    <= `SBR_ENABLE_RST;
            stoppable_reg <= `SBR_STOPPABLE_RST;
            rsvd_reg      <= `SBR_RSVD_RST;
            count_reg     <= `SBR_COUNT_RST;
        end else if (wr_strobe) begin
            case (index_reg)
                `SBR_IDX_MODE:      mode_reg      <= shift_reg;
                `SBR_IDX_ENABLE:    enable_reg    <= shift_reg;
                `SBR_IDX_STOPPABLE: stoppable_reg <= shift_reg;
                `SBR_IDX_RSVD:      rsvd_reg      <= shift_reg;
                `SBR_IDX_COUNT:     count_reg     <= shift_reg;
                default: ;
            endcase
        end
    end

    // pair drive decode
    wire       pd_n      = pd_sync[1];
    wire       halt_n    = halt_sync[1];
    wire [7:0] halted    = {8{~halt_n}} & stoppable_reg & `SBR_STOP_MASK;
    wire [7:0] run_next  = enable_reg & {8{pd_n}} & ~halted;
    wire [7:0] pd_hold   = enable_reg & {8{~pd_n & ~mode_reg[`SBR_PD_HIZ_BIT]}};
    wire [7:0] stop_hold = enable_reg & {8{pd_n & ~mode_reg[`SBR_STOP_HIZ_BIT]}} & halted;

    // registered pair outputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PAIR_RUN     <= 8'h00;
            PAIR_TRUE_OE <= 8'h00;
            PAIR_COMP_OE <= 8'h00;
        end else if (CE) begin
            PAIR_RUN     <= run_next;
            PAIR_TRUE_OE <= run_next | pd_hold | stop_hold;
            PAIR_COMP_OE <= run_next;
        end
    end

    // link pin and configuration outputs
    assign SDA_OUT            = 1'h0;
    assign SDA_OE             = sda_oe_reg;
    assign LOOP_BANDWIDTH_SEL = mode_reg[`SBR_LOW_BW_BIT];
    assign ZERO_DELAY_MODE    = mode_reg[`SBR_ZDB_BIT];
    assign INPUT_DIVIDE_SEL   = mode_reg[`SBR_UNITY_BIT];

    // checks
    ack_hold_a: assert property (@(posedge CLK) disable iff (RST)
        state_reg == sbr_pkg::ST_ACK |-> sda_oe_reg) else $error("ack not driven");
    addr_reject_a: assert property (@(posedge CLK) disable iff (RST)
        (rx_end && phase_reg == sbr_pkg::PH_ADDR && !addr_wr && !addr_rd)
        |=> !sda_oe_reg && state_reg == sbr_pkg::ST_IDLE) else $error("foreign acked");
    index_load_a: assert property (@(posedge CLK) disable iff (RST)
        (rx_end && phase_reg == sbr_pkg::PH_INDEX) |=> index_reg == $past(shift_reg))
        else $error("index not loaded");
    count_first_a: assert property (@(posedge CLK) disable iff (RST)
        (scl_fall && state_reg == sbr_pkg::ST_ACK && read_reg && phase_reg == sbr_pkg::PH_ADDR)
        |=> state_reg == sbr_pkg::ST_TX && sda_oe_reg == ~count_reg[7])
        else $error("count not first");
    index_step_a: assert property (@(posedge CLK) disable iff (RST)
        (scl_fall && !scl_rise && state_reg == sbr_pkg::ST_HACK && !stop_ev && !start_ev)
        |=> index_reg == $past(index_reg) + 8'h01) else $error("index not stepped");
    nack_end_a: assert property (@(posedge CLK) disable iff (RST)
        (scl_rise && sda_s && state_reg == sbr_pkg::ST_HACK && !stop_ev && !start_ev)
        |=> state_reg == sbr_pkg::ST_IDLE ##1 !sda_oe_reg) else $error("read not ended");
    mode_reset_a: assert property (@(posedge CLK)
        $fell(RST) |-> mode_reg[2:0] == 3'h7 && enable_reg == 8'hff && stoppable_reg == 8'h00)
        else $error("bad reset");
    pd_drive_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && !pd_n && !mode_reg[7])
        |=> PAIR_TRUE_OE == $past(enable_reg) && PAIR_COMP_OE == 8'h00)
        else $error("power-down drive");
    stop_pair_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && pd_n && !halt_n && stoppable_reg[1] && enable_reg[1])
        |=> !PAIR_RUN[1] && PAIR_TRUE_OE[1] == !$past(mode_reg[6]))
        else $error("stop drive");
    count_write_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_strobe && index_reg == `SBR_IDX_COUNT) |=> count_reg == $past(shift_reg))
        else $error("count not written");
endmodule
`default_nettype wire

//--- tb/sbr_host.sv
// behavioural two-wire host that drives the link clock and data of the target
// assumes: data line has a pull-up; clk is the 25 MHz system clock, one bit is 8 clk
`timescale 1ns/10ps
`default_nettype none
module sbr_host (
    // timing reference
    input  wire logic clk,
    // two-wire link, clock driven, data open drain from this side
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // idle link: clock high and still, data released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // wait n falling edges of clk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // start or repeated start, data falls while clock high
    task automatic start(input logic rep);
        if (rep) begin
            scl = 1'b0;
            tick(4);
        end
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
    endtask

    // stop, data rises while clock high
    task automatic stop();
        scl = 1'b0;
        tick(4);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask

    // one bit: set data while clock low, sample in the middle of clock high
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        tick(1);
        sda_low = ~b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(2);
    endtask

    // a byte msb first then the ninth bit; ack_tx 0 acknowledges a read byte
    task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
                           output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_tx, ack_rx);
    endtask
endmodule
`default_nettype wire

//--- tb/sbr_target_tb_top.sv
// self-checking bench for the serial register target and pair controls
// assumes: sbr_host on the link, pull-up on the data line, 25 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_target_tb_top;
    logic       clk = 1'b0;           // system clock
    logic       rst = 1'b1;           // reset, held at start
    logic       pd_n = 1'b1;          // power-down request, active low
    logic       halt_n = 1'b1;        // stop request, active low
    logic       ce = 1'b1;            // clock enable of the target
    logic       ack_bit;              // ninth bit as the host saw it
    wire logic  scl;                  // link clock from host
    wire logic  host_low;             // host pulls data low
    wire logic  sda;                  // resolved data line
    logic       sda_out;              // target data value
    logic       sda_oe;               // target pulls data low
    logic       lbw, zdm, ids;        // mode outputs
    logic [7:0] run, toe, coe;        // pair state
    logic [7:0] rcnt;                 // count byte of last read
    logic [7:0] rd [0:7];             // data bytes of last read
    logic [7:0] rst_exp [0:4] = '{8'h07, 8'hff, 8'h00, 8'h00, 8'h00};
    int         errors = 0;
    int         total_checks = 0;

    // 40 ns clock
    always #20 clk = ~clk;
    // wired-and with pull-up
    assign sda = (host_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

    sbr_host i_sbr_host (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda));

    sbr_target i_sbr_target (
        .CLK(clk), .RST(rst), .CE(ce), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .POWER_DOWN_N(pd_n), .OUTPUT_HALT_N(halt_n),
        .LOOP_BANDWIDTH_SEL(lbw), .ZERO_DELAY_MODE(zdm), .INPUT_DIVIDE_SEL(ids),
        .PAIR_RUN(run), .PAIR_TRUE_OE(toe), .PAIR_COMP_OE(coe)
    );

    // byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // indexed block read of n bytes after the count
    task automatic read_blk(input logic [7:0] idx, input int n);
        logic [7:0] d;
        logic       a;
        i_sbr_host.start(1'b0);
        i_sbr_host.byte_io(`SBR_ADDR_WR, 1'b1, d, a);
        chk({7'h00, a}, 8'h00);
        i_sbr_host.byte_io(idx, 1'b1, d, a);
        chk({7'h00, a}, 8'h00);
        i_sbr_host.start(1'b1);
        i_sbr_host.byte_io(`SBR_ADDR_RD, 1'b1, d, a);
        chk({7'h00, a}, 8'h00);
        i_sbr_host.byte_io(8'hff, 1'b0, rcnt, a);
        for (int k = 0; k < n; k++) begin
            i_sbr_host.byte_io(8'hff, k == n - 1, rd[k], a);
        end
        i_sbr_host.stop();
    endtask

    // write one register through the block write sequence
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
        logic [7:0] d;
        logic       a;
        i_sbr_host.start(1'b0);
        i_sbr_host.byte_io(`SBR_ADDR_WR, 1'b1, d, a);
        chk({7'h00, a}, 8'h00);
        i_sbr_host.byte_io(idx, 1'b1, d, a);
        i_sbr_host.byte_io(8'h01, 1'b1, d, a);
        i_sbr_host.byte_io(data, 1'b1, d, a);
        chk({7'h00, a}, 8'h00);
        i_sbr_host.stop();
    endtask

    // verdict and end of run
    task automatic complete_run();
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected 0.18 ms of traffic
    initial begin
        #3000000;
        errors++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        i_sbr_host.tick(4);
        chk({5'h00, lbw, zdm, ids}, 8'h07);
        chk(run, 8'hff);
        read_blk(8'h00, 5);
        chk(rcnt, 8'h05);
        for (int k = 0; k < 5; k++) begin
            chk(rd[k], rst_exp[k]);
        end
        // a foreign address gets no acknowledge
        i_sbr_host.start(1'b0);
        i_sbr_host.byte_io(8'ha0, 1'b1, rcnt, ack_bit);
        chk({7'h00, ack_bit}, 8'h01);
        i_sbr_host.stop();
        write_reg(8'h00, 8'h00);
        chk({5'h00, lbw, zdm, ids}, 8'h00);
        write_reg(8'h01, 8'h5a);
        chk(run, 8'h5a);
        chk((toe | coe) & 8'ha5, 8'h00);
        write_reg(8'h03, 8'hc3);
        write_reg(8'h06, 8'h03);
        read_blk(8'h01, 3);
        chk(rcnt, 8'h03);
        chk(rd[0], 8'h5a);
        chk(rd[1], 8'h00);
        chk(rd[2], 8'hc3);
        read_blk(8'h04, 3);
        chk(rd[0], 8'h00);
        chk(rd[1], 8'h00);
        chk(rd[2], 8'h03);
        // power-down, driven then floating
        pd_n = 1'b0;
        i_sbr_host.tick(6);
        chk(run, 8'h00);
        chk(toe, 8'h5a);
        chk(coe, 8'h00);
        write_reg(8'h00, 8'h86);
        chk({5'h00, lbw, zdm, ids}, 8'h06);
        chk(toe, 8'h00);
        pd_n = 1'b1;
        // stop request, reserved stoppable bits set too
        write_reg(8'h01, 8'hff);
        write_reg(8'h02, 8'hff);
        halt_n = 1'b0;
        i_sbr_host.tick(6);
        chk(run, 8'h99);
        chk(toe & 8'h66, 8'h66);
        write_reg(8'h00, 8'h42);
        chk({5'h00, lbw, zdm, ids}, 8'h02);
        chk(toe & 8'h66, 8'h00);
        chk(coe & 8'h66, 8'h00);
        halt_n = 1'b1;
        i_sbr_host.tick(6);
        chk(run, 8'hff);
        // reset in mid-run restores the defaults
        rst = 1'b1;
        i_sbr_host.tick(2);
        rst = 1'b0;
        i_sbr_host.tick(4);
        chk({5'h00, lbw, zdm, ids}, 8'h07);
        // clock enable low freezes the pair state
        ce = 1'b0;
        pd_n = 1'b0;
        i_sbr_host.tick(6);
        chk(run, 8'hff);
        ce = 1'b1;
        i_sbr_host.tick(6);
        chk(run, 8'h00);
        chk(toe, 8'hff);
        complete_run();
    end
endmodule
`default_nettype wire
